/* File: lmsf_defines.vh */
`ifndef LMSF_DEFINES_VH
`define LMSF_DEFINES_VH
// register word indices (printed offsets are not all multiples of four: byte address is index times four)
`define LMSF_IDX_CUR_LIMIT   8'h03
`define LMSF_IDX_MODE        8'h04
`define LMSF_IDX_FRAME_CTL   8'h1B
`define LMSF_IDX_DETECT      8'h1C
`define LMSF_IDX_STATUS_LO   8'h2D
`define LMSF_IDX_STATUS_HI   8'h74
`define LMSF_IDX_SCROLL      8'h75
`define LMSF_IDX_DISCH_CFG   8'h7E
// mode register fields
`define LMSF_MODE_SCROLL_BIT 1
`define LMSF_MODE_GHOST_BIT  2
// scroll register fields
`define LMSF_SCR_LEFT_BIT    0
`define LMSF_SCR_UP_BIT      1
`define LMSF_SCR_STOP_LSB    2
`define LMSF_SCR_STOP_MSB    6
// status byte fields (one byte per two leds)
`define LMSF_ST_SEL_BIT      0
`define LMSF_ST_OPEN_BIT     1
`define LMSF_ST_SHORT_BIT    2
// timing counts in clocks, then matrix size, status byte count and unmapped read data
`define LMSF_DEAD_CLKS       4
`define LMSF_DISCH_CLKS      2
`define LMSF_DISCH_START     1
`define LMSF_DRIVE_CLKS      16'h0020
`define LMSF_STEP_CLKS       16'h0008
`define LMSF_ROWS            12
`define LMSF_COLS            13
`define LMSF_LEDS            72
`define LMSF_UNMAPPED_DATA   32'h0000_0000
`endif

/* File: lmsf_status_mem.v */
`timescale 1ns/1ps
// status bytes, one shared by each two leds, registered read port
module lmsf_status_mem #(
   parameter DEPTH = 72,
   parameter AW    = 7
) (
   input  wire         clk,
   input  wire         we,
   input  wire [AW-1:0] waddr,
   input  wire [7:0]   wdata,
   input  wire [AW-1:0] raddr,
   output reg  [7:0]   rdata
);
   reg [7:0] mem [0:DEPTH-1];

   // synchronous write and registered read
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // lmsf_status_mem

/* File: lmsf_matrix_ctrl.v */
`timescale 1ns/1ps
`include "lmsf_defines.vh"
module lmsf_matrix_ctrl #(
   parameter ROWS = `LMSF_ROWS,
   parameter COLS = `LMSF_COLS
) (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        cmp_open_raw,
   input  wire        cmp_short_raw,
   input  wire        frame_done,
   output reg  [11:0] row_drive_phase,
   output reg  [12:0] column_scan_drive,
   output reg         ghost_discharge,
   output reg         z_half_supply,
   output reg  [4:0]  row_hold,
   output reg         scroll_left,
   output reg         scroll_up,
   output reg         bulk_update,
   output reg         int_n_oe,
   output reg         int_n_out,
   output reg         detect_busy,
   output reg  [4:0]  led_current_limit
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_DRIVE = 4'b0010;
   localparam ST_DEAD  = 4'b0100;
   localparam ST_DONE  = 4'b1000;

   // register state
   reg [7:0]  mode_reg;
   reg        detect_en;
   reg        int_mask;
   reg        int_flag;
   reg [6:0]  scroll_shadow;
   reg [2:0]  bus_stage;
   // detection engine
   reg [3:0]  state;
   reg [3:0]  row_idx;
   reg [3:0]  col_idx;
   reg [15:0] tmr;
   reg [2:0]  dead_cnt;
   reg        ghost_en;
   // synchronisers for comparator pins and frame marker
   reg [2:0]  sync1;
   reg [2:0]  sync2;
   reg        frame_q;
   // memory ports
   reg        mem_we;
   reg [6:0]  mem_waddr;
   reg [7:0]  mem_wdata;
   reg [6:0]  mem_raddr;
   wire [7:0] mem_rdata;
   reg [7:0]  sel_byte;

   // led index of row r, column c; own column skipped, two leds share a status byte
   function [6:0] led_index;
      input [3:0] r;
      input [3:0] c;
      reg   [3:0] cc;
      reg   [7:0] t;
      begin
         cc = (c > r) ? c - 4'h1 : c;
         t = {4'h0, r} * 8'h06 + {4'h0, cc} / 8'h02;
         led_index = t[6:0];
      end
   endfunction

   // word index decode of the avalon address
   function [7:0] reg_index;
      input [9:0] a;
      begin
         reg_index = a[9:2];
      end
   endfunction

   lmsf_status_mem #(
      .DEPTH (`LMSF_LEDS),
      .AW    (7)
   ) u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // two-flop sync of asynchronous comparator outputs and panel frame marker
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         frame_q <= 1'b0;
      end else begin
         sync1 <= {frame_done, cmp_short_raw, cmp_open_raw};
         sync2 <= sync1;
         frame_q <= sync2[2];
      end
   end

   wire frame_edge = sync2[2] & ~frame_q;
   wire scroll_on  = mode_reg[`LMSF_MODE_SCROLL_BIT];
   wire [7:0] widx = reg_index(avs_address);
   wire bus_req    = (avs_read | avs_write) & ~(|bus_stage);
   wire bus_wr     = bus_stage[2] & avs_write;
   wire st_hit     = (widx >= `LMSF_IDX_STATUS_LO) && (widx <= `LMSF_IDX_STATUS_HI);
   wire [7:0] st_off  = widx - `LMSF_IDX_STATUS_LO;
   wire [6:0] st_addr = st_off[6:0];

   // avalon slave: stage 0 takes, stage 1 lets memory read settle, stage 2 answers; writes land on the answer edge
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_stage       <= 3'h0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         mode_reg        <= 8'h00;
         detect_en       <= 1'b0;
         int_mask        <= 1'b1;
         led_current_limit <= 5'h00;
         scroll_shadow   <= 7'h00;
         mem_raddr       <= 7'h00;
      end else begin
         bus_stage <= {bus_stage[1:0], bus_req};
         avs_waitrequest <= ~bus_stage[1];
         if (bus_req) begin
            mem_raddr <= st_addr;
         end
         if (bus_wr) begin
            case (widx)
               `LMSF_IDX_CUR_LIMIT: led_current_limit <= avs_writedata[4:0];
               `LMSF_IDX_MODE:      mode_reg <= avs_writedata[7:0];
               `LMSF_IDX_FRAME_CTL: int_mask <= avs_writedata[0];
               `LMSF_IDX_DETECT:    detect_en <= avs_writedata[0];
               `LMSF_IDX_SCROLL:    scroll_shadow <= avs_writedata[6:0];
               default: ;
            endcase
         end else if (state == ST_DONE) begin
            detect_en <= 1'b0;
         end
         if (bus_stage[1] && avs_read) begin
            case (widx)
               `LMSF_IDX_CUR_LIMIT: avs_readdata <= {27'h0, led_current_limit};
               `LMSF_IDX_MODE:      avs_readdata <= {24'h0, mode_reg};
               `LMSF_IDX_FRAME_CTL: avs_readdata <= {30'h0, int_flag, int_mask};
               `LMSF_IDX_DETECT:    avs_readdata <= {30'h0, detect_busy, detect_en};
               `LMSF_IDX_SCROLL:    avs_readdata <= {25'h0, scroll_shadow};
               default: avs_readdata <= st_hit ? {24'h0, sel_byte} : `LMSF_UNMAPPED_DATA;
            endcase
         end
      end
   end

   // status byte seen by a bus read; write-select bits go into memory directly
   always @* begin
      sel_byte = mem_rdata;
   end

   // scroll controls apply from shadow only at frame end or when not scrolling
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         row_hold    <= 5'h00;
         scroll_left <= 1'b0;
         scroll_up   <= 1'b0;
         bulk_update <= 1'b0;
         int_flag    <= 1'b0;
      end else begin
         bulk_update <= 1'b0;
         if (!scroll_on || frame_edge) begin
            scroll_left <= scroll_shadow[`LMSF_SCR_LEFT_BIT];
            scroll_up   <= scroll_shadow[`LMSF_SCR_UP_BIT] & ~scroll_shadow[`LMSF_SCR_LEFT_BIT];
            if (scroll_shadow[`LMSF_SCR_LEFT_BIT]) begin
               row_hold <= scroll_shadow[`LMSF_SCR_STOP_MSB:`LMSF_SCR_STOP_LSB];
            end else begin
               row_hold <= 5'h00;
            end
         end
         if (scroll_on && frame_edge) begin
            bulk_update <= 1'b1;
         end
         // set wins over a clear by the frame register write
         if (scroll_on && frame_edge) begin
            int_flag <= 1'b1;
         end else if (bus_wr && widx == `LMSF_IDX_FRAME_CTL && avs_writedata[1]) begin
            int_flag <= 1'b0;
         end
      end
   end

   // open-drain interrupt: low when flagged and unmasked
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_n_oe  <= 1'b0;
         int_n_out <= 1'b0;
      end else begin
         int_n_oe  <= int_flag & ~int_mask;
         int_n_out <= 1'b0;
      end
   end

   // detection scan: drive, dead time, next column or row
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         row_idx <= 4'h0;
         col_idx <= 4'h0;
         tmr <= 16'h0000;
         dead_cnt <= 3'h0;
         row_drive_phase <= 12'h000;
         column_scan_drive <= 13'h0000;
         detect_busy <= 1'b0;
         mem_we <= 1'b0;
         mem_waddr <= 7'h00;
         mem_wdata <= 8'h00;
         ghost_en <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         ghost_en <= mode_reg[`LMSF_MODE_GHOST_BIT];
         if (bus_wr && st_hit) begin
            mem_we <= 1'b1;
            mem_waddr <= st_addr;
            mem_wdata <= {7'h00, avs_writedata[`LMSF_ST_SEL_BIT]};
         end
         case (state)
            ST_IDLE: begin
               if (detect_en && !detect_busy) begin
                  state <= ST_DRIVE;
                  detect_busy <= 1'b1;
                  row_idx <= 4'h0;
                  col_idx <= 4'h1;
                  tmr <= 16'h0000;
               end
            end
            ST_DRIVE: begin
               row_drive_phase <= 12'h001 << row_idx;
               column_scan_drive <= 13'h0001 << col_idx;
               tmr <= tmr + 16'h0001;
               if (tmr == `LMSF_DRIVE_CLKS) begin
                  // sample comparators; results kept until next run
                  mem_we <= 1'b1;
                  mem_waddr <= led_index(row_idx, col_idx);
                  mem_wdata <= {5'h00, sync2[1], sync2[0], 1'b1};
                  state <= ST_DEAD;
                  dead_cnt <= 3'h0;
                  tmr <= 16'h0000;
               end
            end
            ST_DEAD: begin
               row_drive_phase <= 12'h000;
               column_scan_drive <= 13'h0000;
               dead_cnt <= dead_cnt + 3'h1;
               if (dead_cnt == `LMSF_DEAD_CLKS - 1) begin
                  state <= ST_DRIVE;
                  if (col_idx == COLS - 1 || (col_idx == COLS - 2 && row_idx + 4'h1 == COLS - 1)) begin
                     if (row_idx == ROWS - 1) begin
                        state <= ST_DONE;
                     end else begin
                        row_idx <= row_idx + 4'h1;
                        col_idx <= (row_idx == 4'h0) ? 4'h0 : 4'h0;
                     end
                  end else if (col_idx + 4'h1 == row_idx) begin
                     col_idx <= col_idx + 4'h2;
                  end else begin
                     col_idx <= col_idx + 4'h1;
                  end
               end
            end
            ST_DONE: begin
               detect_busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ghost discharge inside dead interval, outputs to half supply
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ghost_discharge <= 1'b0;
         z_half_supply   <= 1'b0;
      end else begin
         if (ghost_en && state == ST_DEAD && dead_cnt >= `LMSF_DISCH_START - 1 &&
             dead_cnt < `LMSF_DISCH_START - 1 + `LMSF_DISCH_CLKS) begin
            ghost_discharge <= 1'b1;
            z_half_supply   <= 1'b1;
         end else begin
            ghost_discharge <= 1'b0;
            z_half_supply   <= 1'b0;
         end
      end
   end
endmodule // lmsf_matrix_ctrl

/* File: lmsf_props.sv */
`timescale 1ns/1ps
// port checker for the matrix control block
module lmsf_props (
   input wire        clk,
   input wire        arst_n,
   input wire [9:0]  avs_address,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire        avs_waitrequest,
   input wire [11:0] row_drive_phase,
   input wire [12:0] column_scan_drive,
   input wire        ghost_discharge,
   input wire        z_half_supply,
   input wire [4:0]  row_hold,
   input wire        scroll_left,
   input wire        scroll_up,
   input wire        bulk_update,
   input wire        detect_busy
);
   reg        ghost_en;
   reg        scroll_en;
   reg [11:0] last_row;
   // shadow of mode bits and last active row drive
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ghost_en  <= 1'b0;
         scroll_en <= 1'b0;
         last_row  <= 12'h000;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == 10'h010) begin
            ghost_en  <= avs_writedata[2];
            scroll_en <= avs_writedata[1];
         end
         if (!detect_busy)
            last_row <= 12'h000;
         else if (row_drive_phase != 12'h000)
            last_row <= row_drive_phase;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_ghost_off_low: assert property (!ghost_en && !$past(ghost_en) && !$past(ghost_en, 2) |-> !ghost_discharge)
      else $error("discharge while disabled");
   a_disch_two_clks: assert property ($rose(ghost_discharge) |=> ghost_discharge ##1 !ghost_discharge)
      else $error("discharge width wrong");
   a_half_supply: assert property (ghost_discharge == z_half_supply)
      else $error("half supply not tied to discharge");
   a_own_col_low: assert property ((row_drive_phase & column_scan_drive[11:0]) == 12'h000)
      else $error("own column driven");
   a_row_onehot: assert property ($onehot0(row_drive_phase))
      else $error("rows not one-hot");
   a_row_order: assert property (row_drive_phase != 12'h000 && row_drive_phase != last_row |->
      row_drive_phase == ((last_row == 12'h000) ? 12'h001 : {last_row[10:0], 1'b0}))
      else $error("row order wrong");
   a_idle_no_drive: assert property (!detect_busy && !$past(detect_busy) |-> row_drive_phase == 12'h000)
      else $error("row driven while idle");
   a_left_wins: assert property (!(scroll_left && scroll_up))
      else $error("both directions applied");
   a_hold_left_only: assert property (row_hold != 5'h00 |-> scroll_left)
      else $error("hold without left");
   a_hold_at_frame: assert property (scroll_en && $past(scroll_en) && $changed(row_hold)
      |-> bulk_update || $past(bulk_update))
      else $error("hold changed mid frame");
   c_ghost: cover property ($rose(ghost_discharge));
   c_detect: cover property ($fell(detect_busy));
   c_bulk: cover property (bulk_update);
endmodule // lmsf_props

bind lmsf_matrix_ctrl lmsf_props chk_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .row_drive_phase(row_drive_phase), .column_scan_drive(column_scan_drive),
   .ghost_discharge(ghost_discharge), .z_half_supply(z_half_supply), .row_hold(row_hold),
   .scroll_left(scroll_left), .scroll_up(scroll_up), .bulk_update(bulk_update), .detect_busy(detect_busy));

/* File: lmsf_panel_model.sv */
`timescale 1ns/1ps
// led panel stand-in: comparator levels and frame edge
module lmsf_panel_model (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [12:0] column_scan_drive,
   input  wire        open_req,
   input  wire        short_req,
   input  wire        frame_kick,
   output reg         cmp_open_raw,
   output reg         cmp_short_raw,
   output reg         frame_done
);
   reg [2:0] hold_cnt;
   // comparators report only while a column is scanned; frame edge held 4 clocks
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_open_raw  <= 1'b0;
         cmp_short_raw <= 1'b0;
         frame_done    <= 1'b0;
         hold_cnt      <= 3'h0;
      end else begin
         cmp_open_raw  <= open_req & (|column_scan_drive);
         cmp_short_raw <= short_req & (|column_scan_drive);
         if (frame_kick)
            hold_cnt <= 3'h4;
         else if (hold_cnt != 3'h0)
            hold_cnt <= hold_cnt - 3'h1;
         frame_done <= frame_kick | (hold_cnt > 3'h1);
      end
   end
endmodule // lmsf_panel_model

/* File: led_matrix_scan_features_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin failures = failures + 1; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module led_matrix_scan_features_tb;
   reg         clk, arst_n, avs_read, avs_write, open_req, short_req, frame_kick;
   reg  [9:0]  avs_address;
   reg  [31:0] avs_writedata, rd;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, cmp_open_raw, cmp_short_raw, frame_done;
   wire [11:0] row_drive_phase;
   wire [12:0] column_scan_drive;
   wire        ghost_discharge, z_half_supply, scroll_left, scroll_up, bulk_update, detect_busy;
   wire        int_n_oe, int_n_out;
   wire [4:0]  row_hold, led_current_limit;
   integer     failures, cmp_count, i, n, ghost_hi;
   reg  [11:0] rows_seen;
   reg  [31:0] sdat [0:2];
   reg  [6:0]  sexp [0:2];
   lmsf_matrix_ctrl dut_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmp_open_raw(cmp_open_raw), .cmp_short_raw(cmp_short_raw),
      .frame_done(frame_done), .row_drive_phase(row_drive_phase), .column_scan_drive(column_scan_drive),
      .ghost_discharge(ghost_discharge), .z_half_supply(z_half_supply), .row_hold(row_hold),
      .scroll_left(scroll_left), .scroll_up(scroll_up), .bulk_update(bulk_update), .int_n_oe(int_n_oe),
      .int_n_out(int_n_out), .detect_busy(detect_busy), .led_current_limit(led_current_limit));
   lmsf_panel_model panel_u (.clk(clk), .arst_n(arst_n), .column_scan_drive(column_scan_drive),
      .open_req(open_req), .short_req(short_req), .frame_kick(frame_kick), .cmp_open_raw(cmp_open_raw),
      .cmp_short_raw(cmp_short_raw), .frame_done(frame_done));
   // clock and hang limit
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #2500000;
      failures = failures + 1;
      finish_test;
   end
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // one bus transfer, set after an edge and held until waitrequest is sampled low at a rising edge
   task bus(input [7:0] idx, input wr, input [31:0] wd, output [31:0] rdv);
      integer k;
      begin
         k = 0;
         @(posedge clk);
         avs_address <= {idx, 2'b00};
         avs_writedata <= wd;
         avs_write <= wr;
         avs_read <= !wr;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0 && k < 40) begin
            @(posedge clk);
            k = k + 1;
         end
         rdv = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         if (k >= 40) begin
            failures = failures + 1;
            finish_test;
         end
      end
   endtask
   // one full detection pass over every row, then the status of the first led
   task run_detect(input [31:0] exp_st, input exp_g);
      begin
         bus(8'h2D, 1'b1, 32'h1, rd);
         bus(8'h1C, 1'b1, 32'h1, rd);
         rows_seen = 12'h000;
         ghost_hi = 0;
         n = 0;
         do begin
            @(negedge clk);
            rows_seen = rows_seen | row_drive_phase;
            ghost_hi = ghost_hi + ghost_discharge;
            n = n + 1;
         end while ((detect_busy !== 1'b0 || n < 8) && n < 20000);
         if (n >= 20000) begin
            failures = failures + 1;
            finish_test;
         end
         `CHK("rows", 12'hFFF, rows_seen)
         `CHK("ghost", exp_g, ghost_hi != 0)
         bus(8'h2D, 1'b0, 32'h0, rd);
         `CHK("status", exp_st, rd)
         bus(8'h1C, 1'b0, 32'h0, rd);
         `CHK("detect", 32'h0, rd)
      end
   endtask
   initial begin
      {arst_n, avs_read, avs_write, open_req, short_req, frame_kick} = 6'h00;
      avs_address = 10'h000;
      avs_writedata = 32'h0;
      failures = 0;
      cmp_count = 0;
      sdat[0] = 32'h7D; sexp[0] = 7'h7E;
      sdat[1] = 32'h7E; sexp[1] = 7'h01;
      sdat[2] = 32'h03; sexp[2] = 7'h02;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      `CHK("wait_rst", 1'b1, avs_waitrequest)
      `CHK("hold_rst", 5'h00, row_hold)
      bus(8'h03, 1'b1, 32'h05, rd);
      bus(8'h03, 1'b0, 32'h0, rd);
      `CHK("limit", 32'h05, rd)
      `CHK("limit_pin", 5'h05, led_current_limit)
      bus(8'h80, 1'b0, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      open_req <= 1'b1;
      run_detect(32'h3, 1'b0);
      open_req <= 1'b0;
      short_req <= 1'b1;
      bus(8'h04, 1'b1, 32'h4, rd);
      run_detect(32'h5, 1'b1);
      short_req <= 1'b0;
      repeat (200) @(posedge clk);
      bus(8'h2D, 1'b0, 32'h0, rd);
      `CHK("retain", 32'h5, rd)
      bus(8'h04, 1'b1, 32'h2, rd);
      bus(8'h1B, 1'b1, 32'h0, rd);
      for (i = 0; i < 3; i = i + 1) begin
         bus(8'h75, 1'b1, sdat[i], rd);
         repeat (20) @(negedge clk);
         `CHK("defer", (i == 0) ? 7'h00 : sexp[i-1], {row_hold, scroll_left, scroll_up})
         @(posedge clk) frame_kick <= 1'b1;
         @(posedge clk) frame_kick <= 1'b0;
         n = 0;
         do begin
            @(negedge clk);
            n = n + 1;
         end while (bulk_update !== 1'b1 && n < 50);
         `CHK("bulk", 1'b1, bulk_update)
         if (bulk_update !== 1'b1)
            finish_test;
         repeat (4) @(negedge clk);
         `CHK("scroll", sexp[i], {row_hold, scroll_left, scroll_up})
         `CHK("irq", 1'b1, int_n_oe)
         `CHK("irq_pin", 1'b0, int_n_out)
         bus(8'h1B, 1'b1, 32'h2, rd);
         repeat (2) @(negedge clk);
         `CHK("irq_clr", 1'b0, int_n_oe)
      end
      finish_test;
   end
endmodule // led_matrix_scan_features_tb
